/* logic/io_led_cfg.svh */
// register offsets, field positions, reset values and timing for the status led block
`ifndef IO_LED_CFG_SVH
`define IO_LED_CFG_SVH
`define LED_CLK_MHZ 100
`define LED_MS_NS 1000000
`define LED_CYC_PER_MS (`LED_MS_NS * `LED_CLK_MHZ / 1000)
`define LED_OW_ON_MS 64
`define LED_OW_OFF_MS 64
`define LED_OW_GAP_MS 2000
`define LED_OW_PERIOD_MS (3 * 64 + 2000)
`define LED_FLASH_HALF_MS 250
`define LED_PU_TOTAL_MS 2000
`define LED_PU_HALF_MS 500
`define LED_REG_CTRL 4'h0
`define LED_REG_STATUS 4'h4
`define LED_REG_TRIP_LO 4'h8
`define LED_REG_TRIP_HI 4'hC
`define LED_CTRL_CFG_BIT 0
`define LED_CTRL_KIND_LSB 1
`define LED_CTRL_RESET 3'h0
`define LED_ST_BANK_BIT 0
`define LED_ST_PU_BIT 1
`define LED_ST_TRIP_BIT 2
`endif

/* logic/io_led_pkg.sv */
// types shared by the status led block
package io_led_pkg;
  typedef enum logic [1:0] {
    KIND_IN,
    KIND_OUT,
    KIND_MIX16,
    KIND_MIX8
  } kind_t;
endpackage : io_led_pkg

/* logic/io_led_ctrl.sv */
// status and channel led control of a discrete i/o module, wishbone register slave
//
// Contract
// - active output overloaded or shorted trips off, flashes its led, lights io led.
// - err led steady for internal event, flashing on cpu link loss, else off.
// - io led steady for overload/short/supply error, flashing for miswiring, else off.
// - bank led lit while channels 32..63 shown, off for 0..31.
// - channel led shows 1 lit, 0 off, flashing on error/overload/short/open wire.
// - open wire pattern repeats on 64 ms, off 64, on 64, off 2000.
// - push-button toggles displayed bank; reset shows first 32 channels.
// - 64-channel module multiplexes both banks onto 32 channel leds.
// - mixed module shows inputs on first leds; 16/16 uses leds 0-15 and 16-31.
// - 8/8 mixed module maps inputs to leds 0-7, outputs to leds 16-23.
// - after sensor supply loss io led lights, input leds hold last value.
// - internal and external event display suppressed until module configured.
// - after reset run, err, io and channel leds flash twice over about 2 seconds; bank led stays off (the code still lets a button press light it).
// - detected event latches channel status until its cause is removed.
`timescale 1ns/100ps
`include "io_led_cfg.svh"
module io_led_ctrl #(
  parameter int NCH = 64,
  parameter int CYC_PER_MS = `LED_CYC_PER_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic [NCH-1:0] chan_in_i,
  input wire logic [NCH-1:0] out_cmd_i,
  input wire logic [NCH-1:0] overload_i,
  input wire logic [NCH-1:0] open_wire_i,
  input wire logic [NCH-1:0] chan_err_i,
  input wire logic sensor_fail_i,
  input wire logic preact_fail_i,
  input wire logic miswire_i,
  input wire logic internal_err_i,
  input wire logic cpu_link_lost_i,
  input wire logic bank_button_i,
  output logic [NCH-1:0] out_drive_o,
  output logic led_run_o,
  output logic led_err_o,
  output logic led_io_o,
  output logic led_bank_o,
  output logic [31:0] led_chan_o
);
  localparam int MSW = $clog2(CYC_PER_MS);
  localparam logic [11:0] OW_P = 12'(`LED_OW_PERIOD_MS);
  localparam logic [11:0] PU_T = 12'(`LED_PU_TOTAL_MS);

  // only the two documented module widths can be mapped onto 32 leds
  if (NCH != 32 && NCH != 64) begin : g_bad
    $error("io_led_ctrl: NCH must be 32 or 64");
  end
  if (CYC_PER_MS < 2) begin : g_bad_ms
    $error("io_led_ctrl: CYC_PER_MS too small");
  end

  logic [MSW-1:0] cyc_reg, cyc_next;
  logic ms_tick;
  logic [11:0] ow_reg, ow_next;
  logic [8:0] fl_reg, fl_next;
  logic fl_on_reg, fl_on_next;
  logic [11:0] pu_reg, pu_next;
  logic pu_busy, pu_on, ow_on;

  // time base: cycle divider gives a 1 ms enable pulse
  always_comb begin
    ms_tick = (cyc_reg == MSW'(CYC_PER_MS - 1));
    cyc_next = ms_tick ? '0 : cyc_reg + 1'b1;
    ow_next = ow_reg;
    fl_next = fl_reg;
    fl_on_next = fl_on_reg;
    pu_next = pu_reg;
    if (ms_tick) begin
      ow_next = (ow_reg == OW_P - 12'h001) ? 12'h000 : ow_reg + 12'h001;
      if (fl_reg == 9'(`LED_FLASH_HALF_MS - 1)) begin
        fl_next = 9'h000;
        fl_on_next = !fl_on_reg;
      end else begin
        fl_next = fl_reg + 9'h001;
      end
      if (pu_busy) begin
        pu_next = pu_reg + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_reg <= '0;
      ow_reg <= 12'h000;
      fl_reg <= 9'h000;
      fl_on_reg <= 1'b1;
      pu_reg <= 12'h000;
    end else begin
      cyc_reg <= cyc_next;
      ow_reg <= ow_next;
      fl_reg <= fl_next;
      fl_on_reg <= fl_on_next;
      pu_reg <= pu_next;
    end
  end

  // two flashes: on 500, off 500, on 500, off 500 ms
  assign pu_busy = (pu_reg < PU_T);
  assign pu_on = pu_busy && (pu_reg < 12'(`LED_PU_HALF_MS) ||
                 (pu_reg >= 12'(2 * `LED_PU_HALF_MS) && pu_reg < 12'(3 * `LED_PU_HALF_MS)));
  assign ow_on = (ow_reg < 12'(`LED_OW_ON_MS)) ||
                 (ow_reg >= 12'(`LED_OW_ON_MS + `LED_OW_OFF_MS) &&
                  ow_reg < 12'(2 * `LED_OW_ON_MS + `LED_OW_OFF_MS));

  logic cfg_reg, cfg_next;
  io_led_pkg::kind_t kind_reg, kind_next;
  logic bank_reg, bank_next, btn_reg;
  logic [31:0] dat_next;
  logic ack_next;
  logic [NCH-1:0] trip_reg, trip_next, held_reg, held_next, drive_next;
  logic [NCH-1:0] fault_reg, fault_next, open_reg, open_next;
  logic [63:0] trip64;
  logic wr;

  assign trip64 = 64'(trip_reg);
  assign wr = cyc_i && stb_i && we_i && !ack_o;

  // register access, bank select, trips and event latches
  always_comb begin
    ack_next = cyc_i && stb_i && !ack_o;
    dat_next = 32'h0000_0000;
    cfg_next = cfg_reg;
    kind_next = kind_reg;
    unique case (adr_i)
      `LED_REG_CTRL: begin
        dat_next = {29'h0000_0000, kind_reg, cfg_reg};
        if (wr && sel_i[0]) begin
          cfg_next = dat_i[`LED_CTRL_CFG_BIT];
          kind_next = io_led_pkg::kind_t'(dat_i[`LED_CTRL_KIND_LSB +: 2]);
        end
      end
      `LED_REG_STATUS: dat_next = {29'h0000_0000, |trip_reg, pu_busy, bank_reg};
      `LED_REG_TRIP_LO: dat_next = trip64[31:0];
      `LED_REG_TRIP_HI: dat_next = trip64[63:32];
      default: dat_next = 32'h0000_0000; // unmapped: acked, reads zero
    endcase
    // only a 64-channel module has a second bank to select
    bank_next = bank_reg ^ (bank_button_i && !btn_reg && NCH == 64);
    // a trip holds the output off until the command is withdrawn
    trip_next = (trip_reg & out_cmd_i) | (overload_i & out_cmd_i);
    drive_next = out_cmd_i & ~trip_next;
    // inputs freeze while the sensor supply is missing
    held_next = sensor_fail_i ? held_reg : chan_in_i;
    // set wins; a latch falls only once its cause is gone
    fault_next = overload_i | chan_err_i | (trip_reg & out_cmd_i);
    open_next = open_wire_i | (open_reg & open_wire_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      cfg_reg <= 1'(`LED_CTRL_RESET); // only the configured bit lives here
      kind_reg <= io_led_pkg::KIND_IN;
      bank_reg <= 1'b0;
      btn_reg <= 1'b0;
      trip_reg <= '0;
      out_drive_o <= '0;
      held_reg <= '0;
      fault_reg <= '0;
      open_reg <= '0;
    end else begin
      ack_o <= ack_next;
      dat_o <= dat_next;
      cfg_reg <= cfg_next;
      kind_reg <= kind_next;
      bank_reg <= bank_next;
      btn_reg <= bank_button_i;
      trip_reg <= trip_next;
      out_drive_o <= drive_next;
      held_reg <= held_next;
      fault_reg <= fault_next;
      open_reg <= open_next;
    end
  end

  // per channel view: level, flashing fault, open wire pattern
  logic [NCH-1:0] ch_vis;
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic is_in, unused_led, lvl;
    assign is_in = kind_reg == io_led_pkg::KIND_IN ||
                   (kind_reg == io_led_pkg::KIND_MIX16 && i < 16) ||
                   (kind_reg == io_led_pkg::KIND_MIX8 && i < 8);
    assign unused_led = kind_reg == io_led_pkg::KIND_MIX8 && ((i >= 8 && i < 16) || i >= 24);
    assign lvl = is_in ? held_reg[i] : out_drive_o[i];
    assign ch_vis[i] = unused_led ? 1'b0 :
                       (cfg_reg && open_reg[i]) ? ow_on :
                       (cfg_reg && fault_reg[i]) ? fl_on_reg : lvl;
  end

  logic [31:0] chan_next;
  logic run_next, err_next, io_next;
  logic ext_err;

  assign ext_err = |overload_i || |trip_reg || sensor_fail_i || preact_fail_i;

  // front panel: power-up flash overrides, events only once configured
  always_comb begin
    chan_next = (NCH == 64 && bank_reg) ? ch_vis[NCH-1 -: 32] : ch_vis[31:0];
    run_next = 1'b1;
    err_next = cfg_reg && (internal_err_i || (cpu_link_lost_i && fl_on_reg));
    io_next = cfg_reg && (ext_err || (miswire_i && fl_on_reg));
    if (pu_busy) begin
      chan_next = {32{pu_on}};
      run_next = pu_on;
      err_next = pu_on;
      io_next = pu_on;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_chan_o <= 32'h0000_0000;
      led_run_o <= 1'b0;
      led_err_o <= 1'b0;
      led_io_o <= 1'b0;
      led_bank_o <= 1'b0;
    end else begin
      led_chan_o <= chan_next;
      led_run_o <= run_next;
      led_err_o <= err_next;
      led_io_o <= io_next;
      led_bank_o <= bank_reg && NCH == 64;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_trip;
    overload_i[0] && out_cmd_i[0] |=> !out_drive_o[0] ##1 (!out_drive_o[0] || !$past(out_cmd_i[0]));
  endproperty
  a_trip: assert property (p_trip) else $error("overloaded output not tripped");

  property p_err_steady;
    cfg_reg && !pu_busy && internal_err_i |=> led_err_o;
  endproperty
  a_err_steady: assert property (p_err_steady) else $error("err led not lit");

  property p_io_steady;
    cfg_reg && !pu_busy && sensor_fail_i |=> led_io_o;
  endproperty
  a_io_steady: assert property (p_io_steady) else $error("io led not lit");

  property p_bank_led;
    !pu_busy ##1 1'b1 |-> led_bank_o == ($past(bank_reg) && NCH == 64);
  endproperty
  a_bank_led: assert property (p_bank_led) else $error("bank led mismatch");

  property p_ow_gap;
    ow_reg >= 12'h0C0 |-> !ow_on;
  endproperty
  a_ow_gap: assert property (p_ow_gap) else $error("open wire led on in gap");

  property p_ow_wrap;
    ms_tick && ow_reg == 12'h88F |=> ow_reg == 12'h000;
  endproperty
  a_ow_wrap: assert property (p_ow_wrap) else $error("open wire period wrong");

  property p_bank_toggle;
    NCH == 64 && bank_button_i && !btn_reg |=> bank_reg != $past(bank_reg);
  endproperty
  a_bank_toggle: assert property (p_bank_toggle) else $error("bank did not toggle");

  property p_mix8_blank;
    kind_reg == io_led_pkg::KIND_MIX8 && !pu_busy |=> !led_chan_o[8] && !led_chan_o[31];
  endproperty
  a_mix8_blank: assert property (p_mix8_blank) else $error("unused led lit");

  property p_hold;
    sensor_fail_i |=> held_reg == $past(held_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("input not held");

  property p_unconfigured;
    !cfg_reg && !pu_busy |=> !led_err_o && !led_io_o;
  endproperty
  a_unconfigured: assert property (p_unconfigured) else $error("event shown unconfigured");

  property p_pu_led;
    pu_busy |=> led_run_o == $past(pu_on);
  endproperty
  a_pu_led: assert property (p_pu_led) else $error("power-up flash wrong");

  property p_latch;
    chan_err_i[0] |=> fault_reg[0];
  endproperty
  a_latch: assert property (p_latch) else $error("event not latched");

  property p_tick;
    ms_tick |=> cyc_reg == '0 && !ms_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("ms base wrong");

  c_trip: cover property (overload_i[0] && out_cmd_i[0] ##1 trip_reg[0]);
  c_bank: cover property (bank_button_i && !btn_reg ##1 bank_reg);
  c_pu_done: cover property (pu_busy ##1 !pu_busy);
  c_ow: cover property (cfg_reg && open_reg[0] && ow_on);
endmodule : io_led_ctrl

/* testbench/front_panel.sv */
// front panel model: bank push-button and the operator's view of the bank
`timescale 1ns/100ps
module front_panel (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic button_o,
  output logic bank_o
);
  logic btn_seen;
  initial begin
    button_o = 1'b0;
  end
  // operator's view: each press flips the shown bank, reset brings the first 32 channels back
  always @(posedge clk_i) begin
    if (rst_i) begin
      bank_o <= 1'b0;
    end else if (button_o && !btn_seen) begin
      bank_o <= ~bank_o;
    end
    btn_seen <= button_o;
  end
  // one press held a few cycles, so exactly one rising edge is seen
  task automatic press();
    @(posedge clk_i);
    button_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    button_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : press
endmodule : front_panel

/* testbench/tb.sv */
// self-checking bench for the status led controller
`timescale 1ns/100ps
module tb;
  localparam int CPM = 2;
  logic clk, rst, we, cyc, stb, ack, sf, pf, mw, ie, cl, btn, run, err, io, bank, pbank, a;
  logic [3:0] adr, sel;
  logic [7:0] b;
  logic [31:0] dw, dr, lc, x, e, m;
  logic [63:0] cin, cmd, ovl, ow, ce, drv;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int errors, checks, cyc_n, n, k;
  io_led_ctrl #(.NCH(64), .CYC_PER_MS(CPM)) io_led_ctrl_i (.clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(dw),
    .dat_o(dr), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .chan_in_i(cin), .out_cmd_i(cmd),
    .overload_i(ovl), .open_wire_i(ow), .chan_err_i(ce), .sensor_fail_i(sf), .preact_fail_i(pf), .miswire_i(mw),
    .internal_err_i(ie), .cpu_link_lost_i(cl), .bank_button_i(btn), .out_drive_o(drv), .led_run_o(run),
    .led_err_o(err), .led_io_o(io), .led_bank_o(bank), .led_chan_o(lc));
  front_panel front_panel_i (.clk_i(clk), .rst_i(rst), .button_o(btn), .bank_o(pbank));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic close_out();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // one classic cycle; the read note is queued for the watcher
  task automatic wb(input logic [3:0] ad, input logic w, input logic [31:0] d, input logic [31:0] ex,
    input logic [31:0] mk);
    exp_q.push_back(ex);
    msk_q.push_back(w ? 32'h0 : mk);
    @(posedge clk);
    adr <= ad;
    we <= w;
    dw <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge clk iff ack === 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic tk(input int c);
    repeat (c) @(posedge clk);
  endtask : tk
  // watcher: each ack retires the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      chk("dat_o", e & m, dr & m);
    end
  end
  // watchdog, the whole run needs about 11300 cycles
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    {we, cyc, stb, sf, pf, mw, ie, cl} = 8'h00;
    {adr, sel, dw} = {4'h0, 4'hF, 32'h0};
    {cin, cmd, ovl, ow, ce} = '0;
    void'($urandom(68588));
    tk(8);
    chk("run_in_reset", 32'h0, run);
    rst <= 1'b0;
    // power-up flash, twice in 2 s, timed from the ms base
    tk(100 * CPM);
    chk("pu_chan_on", 32'hFFFFFFFF, lc);
    chk("pu_io_on", 32'h1, io);
    wb(4'h4, 1'b0, 32'h0, 32'h2, 32'h2);
    tk(650 * CPM);
    chk("pu_chan_off", 32'h0, lc);
    tk(500 * CPM);
    chk("pu_err_on", 32'h1, err);
    tk(900 * CPM);
    chk("run_after_pu", 32'h1, run);
    $display("test power_up done");
    // unconfigured: overload must not reach the io led
    cmd[0] <= 1'b1;
    ovl[0] <= 1'b1;
    tk(4);
    chk("io_unconf", 32'h0, io);
    {cmd, ovl} <= '0;
    wb(4'h0, 1'b1, 32'h1, 32'h0, 32'h0);
    wb(4'h2, 1'b1, 32'hFFFFFFFF, 32'h0, 32'h0);
    wb(4'h2, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF);
    wb(4'h0, 1'b0, 32'h0, 32'h1, 32'h7);
    $display("test registers done");
    // levels and bank selection by push-button
    cin <= {$urandom(), $urandom()};
    tk(4);
    chk("chan_lo", cin[31:0], lc);
    chk("bank_lo", 32'h0, bank);
    front_panel_i.press();
    chk("bank_hi", {31'h0, pbank}, bank);
    chk("chan_hi", cin[63:32], lc);
    wb(4'h4, 1'b0, 32'h0, 32'h1, 32'h1);
    front_panel_i.press();
    chk("bank_back", 32'h0, bank);
    x = lc;
    sf <= 1'b1;
    cin <= ~cin;
    tk(4);
    chk("chan_hold", x, lc);
    chk("io_sensor", 32'h1, io);
    sf <= 1'b0;
    $display("test levels done");
    // fault led steady, then flashing on link loss
    ie <= 1'b1;
    tk(4);
    chk("err_steady", 32'h1, err);
    tk(250 * CPM);
    chk("err_steady2", 32'h1, err);
    ie <= 1'b0;
    cl <= 1'b1;
    tk(4);
    a = err;
    tk(250 * CPM);
    chk("err_flash", {31'h0, ~a}, err);
    cl <= 1'b0;
    pf <= 1'b1;
    tk(4);
    chk("io_preact", 32'h1, io);
    pf <= 1'b0;
    mw <= 1'b1;
    tk(4);
    a = io;
    tk(250 * CPM);
    chk("io_flash", {31'h0, ~a}, io);
    mw <= 1'b0;
    tk(4);
    chk("io_clear", 32'h0, io);
    chk("err_clear", 32'h0, err);
    $display("test module leds done");
    // trip of an overloaded output, latched until the command drops
    wb(4'h0, 1'b1, 32'h3, 32'h0, 32'h0);
    k = $urandom() % 32;
    cmd <= '1;
    ovl[k] <= 1'b1;
    tk(4);
    chk("trip_lo", ~(32'h1 << k), drv[31:0]);
    chk("io_trip", 32'h1, io);
    a = lc[k];
    tk(250 * CPM);
    chk("trip_flash", {31'h0, ~a}, {31'h0, lc[k]});
    wb(4'h8, 1'b0, 32'h0, 32'h1 << k, 32'hFFFFFFFF);
    ovl <= '0;
    tk(4);
    chk("trip_held", ~(32'h1 << k), drv[31:0]);
    cmd <= '0;
    tk(4);
    cmd <= '1;
    tk(4);
    chk("trip_gone", 32'hFFFFFFFF, drv[31:0]);
    // channel error: flashes while present, level returns once it clears
    ce[0] <= 1'b1;
    tk(4);
    a = lc[0];
    tk(250 * CPM);
    chk("ch_err_flash", {31'h0, ~a}, {31'h0, lc[0]});
    ce[0] <= 1'b0;
    tk(4);
    chk("ch_err_gone", 32'h1, {31'h0, lc[0]});
    $display("test trip done");
    // open wire: 2 x 64 ms lit in each 2192 ms period
    wb(4'h0, 1'b1, 32'h1, 32'h0, 32'h0);
    {cmd, cin} <= '0;
    ow[7] <= 1'b1;
    tk(4);
    n = 0;
    repeat (2192 * CPM) begin
      @(posedge clk);
      n += lc[7];
    end
    chk("ow_lit", 32'h100, n);
    ow <= '0;
    $display("test open_wire done");
    // mixed modules: inputs on the first leds, outputs above
    b = 8'($urandom());
    cin <= {8{b}};
    cmd <= {8{~b}};
    wb(4'h0, 1'b1, 32'h5, 32'h0, 32'h0);
    tk(4);
    chk("mix16", {~b, ~b, b, b}, lc);
    wb(4'h0, 1'b1, 32'h7, 32'h0, 32'h0);
    tk(4);
    chk("mix8", {8'h00, ~b, 8'h00, b}, lc);
    $display("test mixed done");
    close_out();
  end
endmodule : tb
